// ===== hdl/smas_pkg.sv
/*
 * Package for the address-size handling block: register map, field layout,
 * encodings and reset values.
 * Assumes a classic Wishbone slave with 32-bit data and word-aligned registers.
 */
// Summary of operation
// - Short-descriptor contexts take stage 1 transient hint from incoming, possibly overridden, attributes.
// - Walk disable bit 0 is honoured also in hypervisor and monitor banks.
// - Secure hypervisor banks apply the walk security attribute from either control register.
// - Stage 1 with stage 2 bypass banks still apply attribute-only second stage.
// - That attribute-only stage also covers the bank's own table walk accesses.
// - Non-secure non-hypervisor banks carry a virtual machine tag, bypass-format too.
// - Instruction-attribute override can make instruction fetches be treated as data.
// - Secure instruction-fetch check is evaluated after the instruction override.
// - User cache maintenance disable applies whether or not translation is enabled.
// - Virtual addresses up to 32 or 49 bits; intermediate and physical up to 48.
// - Upstream width field reports largest upstream address port width.
// - Intermediate width field reports supported intermediate address width.
// - Output width field reports downstream bus width.
// - Without stage 1 support, upstream and intermediate widths read equal.
// - Without stage 2 support, intermediate and output widths read equal.
// - Effective intermediate size is intermediate width, or min with output width for bypass.
// - Output range limit comes from control register 2 for stage 1, control register for stage 2.
// - Bypassed transactions have their address truncated to the output width.
// - Other transactions go to the bank, maybe sign-extended, then checked per stage.
// - Bypass on client bypass bit, unmatched or multi-match without fault, or bypass type.
// - Sign-extension at the position field; nonzero bits above give a level 0 fault.
package smas_pkg;

  localparam int unsigned ADDR_W      = 49;
  localparam int unsigned VA32_W      = 32;
  localparam int unsigned OUT_MAX_W   = 48;

  // Width codes used by the width fields and the range limit.
  localparam logic [2:0] W_32 = 3'h0;
  localparam logic [2:0] W_36 = 3'h1;
  localparam logic [2:0] W_40 = 3'h2;
  localparam logic [2:0] W_42 = 3'h3;
  localparam logic [2:0] W_44 = 3'h4;
  localparam logic [2:0] W_48 = 3'h5;

  // Implemented capabilities; the widths obey the equal-width constraints.
  localparam logic       FIRST_STAGE_SUPPORT  = 1'b1;
  localparam logic       SECOND_STAGE_SUPPORT = 1'b1;
  localparam logic [3:0] UPSTREAM_WIDTH_CODE  = 4'h5;
  localparam logic [3:0] INTERMED_WIDTH_CODE  = 4'h5;
  localparam logic [3:0] OUTPUT_WIDTH_CODE    = 4'h4;

  // Register byte offsets.
  localparam logic [7:0] OFS_ID0     = 8'h00;
  localparam logic [7:0] OFS_ID2     = 8'h04;
  localparam logic [7:0] OFS_GCFG    = 8'h08;
  localparam logic [7:0] OFS_S2CB    = 8'h0C;
  localparam logic [7:0] OFS_BATTR   = 8'h10;
  localparam logic [7:0] OFS_BATTR2  = 8'h14;
  localparam logic [7:0] OFS_BTCR    = 8'h18;
  localparam logic [7:0] OFS_BTCR2   = 8'h1C;
  localparam logic [7:0] OFS_BSCTL   = 8'h20;
  localparam logic [7:0] OFS_SCFG1   = 8'h24;
  localparam logic [7:0] OFS_STATUS  = 8'h28;

  // Field positions.
  localparam int unsigned ID0_S1_BIT   = 30;
  localparam int unsigned ID0_S2_BIT   = 29;
  localparam int unsigned ID2_IW_LSB   = 0;
  localparam int unsigned ID2_OW_LSB   = 4;
  localparam int unsigned ID2_UW_LSB   = 8;
  localparam int unsigned GCFG_CBP     = 0;
  localparam int unsigned GCFG_UMF     = 1;
  localparam int unsigned GCFG_MMF     = 2;
  localparam int unsigned S2CB_TYPE_LSB = 16;
  localparam int unsigned S2CB_INST_LSB = 26;
  localparam int unsigned S2CB_TRANS_BIT = 28;
  localparam int unsigned BATTR_VIRTUAL_MACHINE_TAG_LSB = 0;
  localparam int unsigned BATTR_ATTR_LSB = 12;
  localparam int unsigned BATTR_TYPE_LSB = 16;
  localparam int unsigned BATTR_HYP_BIT  = 20;
  localparam int unsigned BATTR_MON_BIT  = 21;
  localparam int unsigned BATTR_SEC_BIT  = 22;
  localparam int unsigned BATTR2_WIDE_BIT = 0;
  localparam int unsigned BTCR_WD0_BIT   = 7;
  localparam int unsigned BTCR_NSW_BIT   = 14;
  localparam int unsigned BTCR_RNG_LSB   = 16;
  localparam int unsigned BTCR_LONG_BIT  = 31;
  localparam int unsigned BTCR2_RNG_LSB  = 0;
  localparam int unsigned BTCR2_NSW_BIT  = 14;
  localparam int unsigned BTCR2_SEP_LSB  = 15;
  localparam int unsigned BSCTL_EN_BIT   = 0;
  localparam int unsigned BSCTL_UCM_BIT  = 1;
  localparam int unsigned SCFG1_SIF_BIT  = 8;

  localparam logic [31:0] GCFG_RESET = 32'h0000_0001;

  typedef enum logic [1:0] {
    SMAS_ST_TRANS  = 2'b00,
    SMAS_ST_BYPASS = 2'b01,
    SMAS_ST_FAULT  = 2'b10
  } smas_s2type_e;

  typedef enum logic [1:0] {
    SMAS_CB_S2ONLY  = 2'b00,
    SMAS_CB_S1BYP   = 2'b01,
    SMAS_CB_S1S2    = 2'b10
  } smas_cbtype_e;

  typedef enum logic [1:0] {
    SMAS_IC_KEEP = 2'b00,
    SMAS_IC_DATA = 2'b10,
    SMAS_IC_INST = 2'b11
  } smas_inst_e;

  // Incoming transaction.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              instr;
    logic              transient;
    logic              walk;
    logic              matched;
    logic              multi;
  } smas_req_s;

  // Transaction after address handling.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              bypass;
    logic              instr;
    logic              transient;
    logic [3:0]        s2_attr;
    logic              s2_attr_only;
    logic [7:0]        vm_tag;
    logic              walk_ns;
    logic              walk_dis;
    logic              fault;
    logic              sif_fault;
    logic [3:0]        eff_ia_code;
    logic [2:0]        range_code;
  } smas_rsp_s;

  function automatic logic [5:0] code_bits(input logic [3:0] c);
    case (c)
      4'h0: code_bits = 6'd32;
      4'h1: code_bits = 6'd36;
      4'h2: code_bits = 6'd40;
      4'h3: code_bits = 6'd42;
      4'h4: code_bits = 6'd44;
      default: code_bits = 6'd48;
    endcase
  endfunction

endpackage

// ===== hdl/smas_top.sv
/*
 * Address-size and context-format handling of one translation context bank,
 * with its configuration registers on a classic Wishbone slave.
 * Assumes requests arrive from logic on CLK with REQ_VALID; one result per request.
 */
`timescale 1ns/10ps
`default_nettype none
module smas_top (
  input  wire logic                CLK,
  input  wire logic                NRST,
  input  wire logic                WB_CYC_I,
  input  wire logic                WB_STB_I,
  input  wire logic                WB_WE_I,
  input  wire logic [7:0]          WB_ADR_I,
  input  wire logic [3:0]          WB_SEL_I,
  input  wire logic [31:0]         WB_DAT_I,
  output logic [31:0]              WB_DAT_O,
  output logic                     WB_ACK_O,
  input  wire logic                REQ_VALID,
  input  wire smas_pkg::smas_req_s REQ,
  input  wire logic                CMO_USER,
  output logic                     RSP_VALID,
  output smas_pkg::smas_rsp_s      RSP,
  output logic                     CMO_BLOCK
);
  import smas_pkg::*;

  logic [31:0] gcfg_q, s2cb_q, battr_q, battr2_q, btcr_q, btcr2_q, bsctl_q, scfg1_q;
  logic [31:0] status_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        rsp_valid_q;
  smas_rsp_s   rsp_q;
  logic        cmo_block_q;

  ////////////////////////////////////////////////////////////////////////////
  // Identification values.

  logic [31:0] id0;
  logic [31:0] id2;
  logic [3:0]  uw_code, iw_code, ow_code;

  always_comb begin
    // Missing stages force equal widths, so software never sees a contradiction.
    ow_code = OUTPUT_WIDTH_CODE;
    iw_code = SECOND_STAGE_SUPPORT ? INTERMED_WIDTH_CODE : ow_code;
    uw_code = FIRST_STAGE_SUPPORT ? UPSTREAM_WIDTH_CODE : iw_code;
    id0 = 32'h0;
    id0[ID0_S1_BIT] = FIRST_STAGE_SUPPORT;
    id0[ID0_S2_BIT] = SECOND_STAGE_SUPPORT;
    id2 = 32'h0;
    id2[ID2_IW_LSB +: 4] = iw_code;
    id2[ID2_OW_LSB +: 4] = ow_code;
    id2[ID2_UW_LSB +: 4] = uw_code;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero.

  logic        wb_req;
  logic [31:0] wmask;
  logic [31:0] rd_mux;

  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{WB_SEL_I[i]}};
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      gcfg_q   <= GCFG_RESET;
      s2cb_q   <= 32'h0;
      battr_q  <= 32'h0;
      battr2_q <= 32'h0;
      btcr_q   <= 32'h0;
      btcr2_q  <= 32'h0;
      bsctl_q  <= 32'h0;
      scfg1_q  <= 32'h0;
    end else if (wb_req && WB_WE_I) begin
      unique case (WB_ADR_I)
        OFS_GCFG:   gcfg_q   <= merge(gcfg_q, WB_DAT_I, wmask);
        OFS_S2CB:   s2cb_q   <= merge(s2cb_q, WB_DAT_I, wmask);
        OFS_BATTR:  battr_q  <= merge(battr_q, WB_DAT_I, wmask);
        OFS_BATTR2: battr2_q <= merge(battr2_q, WB_DAT_I, wmask);
        OFS_BTCR:   btcr_q   <= merge(btcr_q, WB_DAT_I, wmask);
        OFS_BTCR2:  btcr2_q  <= merge(btcr2_q, WB_DAT_I, wmask);
        OFS_BSCTL:  bsctl_q  <= merge(bsctl_q, WB_DAT_I, wmask);
        OFS_SCFG1:  scfg1_q  <= merge(scfg1_q, WB_DAT_I, wmask);
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (WB_ADR_I)
      OFS_ID0:    rd_mux = id0;
      OFS_ID2:    rd_mux = id2;
      OFS_GCFG:   rd_mux = gcfg_q;
      OFS_S2CB:   rd_mux = s2cb_q;
      OFS_BATTR:  rd_mux = battr_q;
      OFS_BATTR2: rd_mux = battr2_q;
      OFS_BTCR:   rd_mux = btcr_q;
      OFS_BTCR2:  rd_mux = btcr2_q;
      OFS_BSCTL:  rd_mux = bsctl_q;
      OFS_SCFG1:  rd_mux = scfg1_q;
      OFS_STATUS: rd_mux = status_q;
      default:    rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdat_q <= 32'h0;
    end else if (wb_req) begin
      rdat_q <= WB_WE_I ? 32'h0 : rd_mux;
    end
  end

  assign WB_DAT_O = rdat_q;
  assign WB_ACK_O = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction path.

  logic              client_bypass, unmatched_fault_bit, multi_match_fault_bit;
  smas_s2type_e      s2type;
  smas_inst_e        instr_attr_override;
  smas_cbtype_e      cbtype;
  logic              hyp_bank, mon_bank, sec_bank, wide_sel, xlat_en, long_fmt;
  logic              bypass, instr_eff, sif_fault, sext_on, sext_fault, fault;
  logic [5:0]        sign_ext_position, ow_bits, eff_bits, rng_bits, in_bits;
  logic [2:0]        range_code;
  logic [3:0]        eff_code;
  logic [ADDR_W-1:0] trunc_addr, sext_addr, hi_mask;
  smas_rsp_s         rsp_d;

  always_comb begin
    client_bypass         = gcfg_q[GCFG_CBP];
    unmatched_fault_bit   = gcfg_q[GCFG_UMF];
    multi_match_fault_bit = gcfg_q[GCFG_MMF];
    s2type              = smas_s2type_e'(s2cb_q[S2CB_TYPE_LSB +: 2]);
    instr_attr_override = smas_inst_e'(s2cb_q[S2CB_INST_LSB +: 2]);
    cbtype   = smas_cbtype_e'(battr_q[BATTR_TYPE_LSB +: 2]);
    hyp_bank = battr_q[BATTR_HYP_BIT];
    mon_bank = battr_q[BATTR_MON_BIT];
    sec_bank = battr_q[BATTR_SEC_BIT];
    wide_sel = battr2_q[BATTR2_WIDE_BIT];
    xlat_en  = bsctl_q[BSCTL_EN_BIT];
    long_fmt = btcr_q[BTCR_LONG_BIT];

    bypass = client_bypass
           | (~REQ.matched & ~unmatched_fault_bit)
           | (REQ.matched & REQ.multi & ~multi_match_fault_bit)
           | (s2type == SMAS_ST_BYPASS);

    unique case (instr_attr_override)
      SMAS_IC_DATA: instr_eff = 1'b0;
      SMAS_IC_INST: instr_eff = 1'b1;
      default:      instr_eff = REQ.instr;
    endcase
    // Applied after the override: a fetch turned into data is never flagged.
    sif_fault = scfg1_q[SCFG1_SIF_BIT] & instr_eff & REQ.matched & sec_bank;

    ow_bits = code_bits(ow_code);
    hi_mask = '0;
    for (int b = 0; b < ADDR_W; b++) begin
      hi_mask[b] = (6'(b) >= ow_bits);
    end
    trunc_addr = REQ.addr & ~hi_mask;

    // Effective intermediate size used for the output check of stage 1.
    if (cbtype == SMAS_CB_S1BYP && ow_code < iw_code) begin
      eff_code = ow_code;
    end else begin
      eff_code = iw_code;
    end
    eff_bits = code_bits(eff_code);

    range_code = (cbtype == SMAS_CB_S2ONLY) ? btcr_q[BTCR_RNG_LSB +: 3]
                                           : btcr2_q[BTCR2_RNG_LSB +: 3];
    rng_bits = code_bits({1'b0, range_code});
    if (rng_bits > eff_bits) begin
      rng_bits = eff_bits;
    end

    // Input width: 32 bits in narrow format, up to 49 in the wide one.
    in_bits = wide_sel ? 6'(ADDR_W) : 6'(VA32_W);
    if (cbtype == SMAS_CB_S2ONLY) begin
      in_bits = code_bits(iw_code);
    end

    sign_ext_position = btcr2_q[BTCR2_SEP_LSB +: 6];
    if (sign_ext_position > 6'(OUT_MAX_W)) begin
      sign_ext_position = 6'(OUT_MAX_W);
    end
    sext_on = (cbtype != SMAS_CB_S2ONLY) & wide_sel & xlat_en & ~hyp_bank & ~mon_bank;
    sext_addr  = REQ.addr;
    sext_fault = 1'b0;
    if (sext_on) begin
      for (int b = 0; b < ADDR_W; b++) begin
        if (6'(b) > sign_ext_position) begin
          sext_fault = sext_fault | REQ.addr[b];
          sext_addr[b] = REQ.addr[sign_ext_position];
        end
      end
    end

    // Per-stage checks depend on stage, enable and descriptor width.
    fault = sext_fault;
    if (!sext_on && xlat_en) begin
      for (int b = 0; b < ADDR_W; b++) begin
        if (6'(b) >= in_bits) begin
          fault = fault | REQ.addr[b];
        end
      end
    end
    if (!xlat_en) begin
      for (int b = 0; b < ADDR_W; b++) begin
        if (6'(b) >= rng_bits) begin
          fault = fault | REQ.addr[b];
        end
      end
    end
    if (s2type == SMAS_ST_FAULT || (~REQ.matched & unmatched_fault_bit)) begin
      fault = 1'b1;
    end

    rsp_d = '0;
    rsp_d.bypass      = bypass;
    rsp_d.instr       = instr_eff;
    rsp_d.eff_ia_code = eff_code;
    rsp_d.range_code  = range_code;
    if (bypass) begin
      rsp_d.addr = trunc_addr;
    end else begin
      rsp_d.addr      = sext_addr;
      rsp_d.fault     = fault;
      rsp_d.sif_fault = sif_fault;
      // Short descriptors carry no transient bit, so the incoming hint is used.
      rsp_d.transient = REQ.transient;
      if (long_fmt) begin
        rsp_d.transient = REQ.transient & wide_sel;
      end
      // Walk disable is kept for every bank type, hypervisor and monitor too.
      rsp_d.walk_dis = btcr_q[BTCR_WD0_BIT];
      rsp_d.walk_ns  = (hyp_bank & sec_bank)
                     ? (btcr_q[BTCR_NSW_BIT] | btcr2_q[BTCR2_NSW_BIT])
                     : ~sec_bank;
      if (cbtype == SMAS_CB_S1BYP) begin
        rsp_d.s2_attr_only = 1'b1;
        rsp_d.s2_attr      = battr_q[BATTR_ATTR_LSB +: 4];
      end
      if (!sec_bank && !hyp_bank) begin
        rsp_d.vm_tag = battr_q[BATTR_VIRTUAL_MACHINE_TAG_LSB +: 8];
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end else begin
      rsp_valid_q <= REQ_VALID;
      if (REQ_VALID) begin
        rsp_q <= rsp_d;
      end
    end
  end

  // Status keeps the last fault flags and bypass outcome; sticky until next result.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      status_q <= 32'h0;
    end else if (REQ_VALID) begin
      status_q <= {28'h0, cmo_block_q, rsp_d.sif_fault, rsp_d.fault, rsp_d.bypass};
    end
  end

  // User cache maintenance is blocked by the bank control alone, not by enable.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cmo_block_q <= 1'b0;
    end else begin
      cmo_block_q <= CMO_USER & ~bsctl_q[BSCTL_UCM_BIT];
    end
  end

  assign RSP_VALID = rsp_valid_q;
  assign RSP       = rsp_q;
  assign CMO_BLOCK = cmo_block_q;

endmodule // smas_top
`default_nettype wire

// ===== verif/smas_props.sv
/* Checker for the address-size block: bus handshake, response timing and address relations.
   Assumes it is bound to smas_top and sees only that module's ports. */
`timescale 1ns/10ps
`default_nettype none
module smas_props (
  input wire logic                CLK,
  input wire logic                NRST,
  input wire logic                WB_CYC_I,
  input wire logic                WB_STB_I,
  input wire logic                WB_WE_I,
  input wire logic [7:0]          WB_ADR_I,
  input wire logic [3:0]          WB_SEL_I,
  input wire logic [31:0]         WB_DAT_I,
  input wire logic [31:0]         WB_DAT_O,
  input wire logic                WB_ACK_O,
  input wire logic                REQ_VALID,
  input wire smas_pkg::smas_req_s REQ,
  input wire logic                CMO_USER,
  input wire logic                RSP_VALID,
  input wire smas_pkg::smas_rsp_s RSP,
  input wire logic                CMO_BLOCK
);
  import smas_pkg::*;
  // Width code 4 of the output field stands for 44 bits.
  localparam int         OW_BITS = 44;
  localparam logic [3:0] EFF_IA  = (OUTPUT_WIDTH_CODE < INTERMED_WIDTH_CODE) ? OUTPUT_WIDTH_CODE
                                                                            : INTERMED_WIDTH_CODE;
  smas_req_s req_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      req_q <= '0;
    end else begin
      req_q <= REQ;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  ////////////////////////////////////////////////////////////////////////////
  a_ack_follows:
    assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus cycle not acknowledged one cycle later");
  a_ack_pulse:
    assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");
  a_rsp_follows:
    assert property (REQ_VALID |=> RSP_VALID)
    else $error("no response one cycle after request");
  a_rsp_cause:
    assert property (RSP_VALID |-> $past(REQ_VALID))
    else $error("response without request");
  a_rsp_hold:
    assert property (!REQ_VALID |=> $stable(RSP))
    else $error("response changed without request");
  a_byp_trunc:
    assert property (RSP_VALID && RSP.bypass |-> (RSP.addr >> OW_BITS) == '0
                     && RSP.addr[OW_BITS-1:0] == req_q.addr[OW_BITS-1:0])
    else $error("bypass address not truncated to output width");
  a_eff_ia:
    assert property (RSP_VALID && !RSP.bypass && RSP.s2_attr_only |-> RSP.eff_ia_code == EFF_IA)
    else $error("effective intermediate size wrong for bypass-format bank");
  a_id_widths:
    assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == OFS_ID2 |->
                     WB_DAT_O[11:0] == {UPSTREAM_WIDTH_CODE, OUTPUT_WIDTH_CODE, INTERMED_WIDTH_CODE})
    else $error("width fields read wrong");
  a_sif_after:
    assert property (RSP_VALID && RSP.sif_fault |-> RSP.instr && !RSP.bypass && req_q.matched)
    else $error("fetch fault on data, bypassed or unmatched access");
  a_cmo_block:
    assert property (CMO_BLOCK |-> $past(CMO_USER))
    else $error("maintenance blocked without request");
endmodule // smas_props

bind smas_top smas_props u_props (
  .CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .REQ_VALID(REQ_VALID), .REQ(REQ), .CMO_USER(CMO_USER),
  .RSP_VALID(RSP_VALID), .RSP(RSP), .CMO_BLOCK(CMO_BLOCK)
);
`default_nettype wire

// ===== verif/smas_client.sv
/* Upstream client model: issues one transaction at a time into the block.
   Assumes the block takes a request at the edge where the valid pulse is high. */
`timescale 1ns/10ps
`default_nettype none
module smas_client (
  input  wire logic                clk,
  output var  logic                req_valid,
  output var  smas_pkg::smas_req_s req
);
  import smas_pkg::*;

  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // Outside the pulse the lines carry the inverse of the last request, so a
  // block that samples them late picks up visibly wrong values.
  task automatic send(input smas_req_s t, input int unsigned gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= t;
    @(posedge clk);
    req_valid <= 1'b0;
    req       <= ~t;
  endtask
endmodule // smas_client
`default_nettype wire

// ===== verif/tb_top.sv
/* Testbench for the address-size block: registers over Wishbone, transactions through
   the client model, expected values worked out from the field layout.
   Assumes the package offsets; byte enables stay all set since registers are whole words. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import smas_pkg::*;
  localparam int OW_BITS = 44;
  logic        clk, nrst, cyc, stb, we, cmo, ack, req_valid, rsp_valid, cmo_block;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, dat_o;
  smas_req_s   req;
  smas_rsp_s   rsp;
  int          bad_count, tests_run;
  // Each entry: global config[7:5], stream type[4:3], matched, multi, bypass expected.
  logic [7:0]  byp_tab [8] = '{8'h25, 8'h0D, 8'h04, 8'h01, 8'h40, 8'h07, 8'h86, 8'h14};
  // Each entry: override mode[3:2], instruction in, instruction out.
  logic [3:0]  ins_tab [4] = '{4'h3, 4'hA, 4'hD, 4'h0};

  smas_top DUT (
    .CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .REQ_VALID(req_valid),
    .REQ(req), .CMO_USER(cmo), .RSP_VALID(rsp_valid), .RSP(rsp), .CMO_BLOCK(cmo_block)
  );
  smas_client u_cli (.clk(clk), .req_valid(req_valid), .req(req));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t ns: got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    chk(ack, 1'b1);
    rdat = dat_o;
    cyc  <= 1'b0;
    stb  <= 1'b0;
  endtask

  // Gap varies with the comparison count so the client is sometimes slow.
  task automatic xact(input logic [48:0] a, input logic [4:0] f);
    u_cli.send({a, f}, tests_run % 3);
    #1;
    chk(rsp_valid, 1'b1);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    bad_count++;
    $display("[FAIL] %0t ns: run did not finish", $time);
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, cyc, stb, we, cmo, adr, wdat} = '0;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wb(1'b0, OFS_GCFG, '0);
    chk(rdat, 32'h1);
    wb(1'b0, OFS_ID0, '0);
    chk(rdat[30:29], 2'b11);
    wb(1'b1, OFS_ID2, 32'hFFFF_FFFF);
    wb(1'b0, OFS_ID2, '0);
    chk(rdat[11:0], 12'h545);
    wb(1'b0, 8'h2C, '0);
    chk(rdat, 32'h0);
    foreach (byp_tab[i]) begin
      wb(1'b1, OFS_GCFG, {29'h0, byp_tab[i][7:5]});
      wb(1'b1, OFS_S2CB, {14'h0, byp_tab[i][4:3], 16'h0});
      xact({49{1'b1}}, {3'b000, byp_tab[i][2:1]});
      chk(rsp.bypass, byp_tab[i][0]);
      if (byp_tab[i][0]) chk(rsp.addr, (49'h1 << OW_BITS) - 49'h1);
    end
    wb(1'b1, OFS_S2CB, '0);
    wb(1'b1, OFS_BATTR, 32'h0001_A05A);
    xact('0, 5'b00110);
    chk(rsp.s2_attr_only, 1'b1);
    chk(rsp.s2_attr, 4'hA);
    chk(rsp.vm_tag, 8'h5A);
    chk(rsp.eff_ia_code, 4'h4);
    wb(1'b1, OFS_BATTR, 32'h0002_A05A);
    xact('0, 5'b00010);
    chk(rsp.s2_attr_only, 1'b0);
    chk(rsp.eff_ia_code, 4'h5);
    wb(1'b1, OFS_BATTR, 32'h0011_0000);
    wb(1'b1, OFS_BTCR, 32'h0000_0080);
    xact('0, 5'b00110);
    chk(rsp.walk_dis, 1'b1);
    wb(1'b1, OFS_BATTR, 32'h0051_0000);
    wb(1'b1, OFS_BTCR, 32'h0000_4000);
    wb(1'b1, OFS_BTCR2, 32'h0000_4000);
    xact('0, 5'b00110);
    chk(rsp.walk_ns, 1'b1);
    chk(rsp.walk_dis, 1'b0);
    wb(1'b1, OFS_BATTR, 32'h0041_0000);
    wb(1'b1, OFS_BTCR, '0);
    wb(1'b1, OFS_BATTR2, '0);
    wb(1'b1, OFS_SCFG1, 32'h0000_0100);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, OFS_S2CB, {4'h0, ins_tab[i][3:2], 26'h0});
      xact('0, {ins_tab[i][1], i[0], 3'b010});
      chk(rsp.instr, ins_tab[i][0]);
      chk(rsp.sif_fault, ins_tab[i][0]);
      chk(rsp.transient, i[0]);
    end
    @(posedge clk);
    cmo <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, OFS_BSCTL, {30'h0, i[1:0]});
      repeat (2) @(posedge clk);
      #1;
      chk(cmo_block, !i[1]);
    end
    // Secure stage 1 bypass-format bank: range check with translation off, then input
    // check and sign extension with it on.
    wb(1'b1, OFS_BSCTL, '0);
    xact(49'h1_0000_0000, 5'b00010);
    chk(rsp.fault, 1'b1);
    chk(rsp.range_code, W_32);
    xact(49'h0_FFFF_FFFF, 5'b00010);
    chk(rsp.fault, 1'b0);
    wb(1'b1, OFS_BSCTL, 32'h1);
    xact(49'h1_0000_0000, 5'b00010);
    chk(rsp.fault, 1'b1);
    wb(1'b1, OFS_BATTR2, 32'h1);
    wb(1'b1, OFS_BTCR2, 32'h0017_8000);
    xact(49'h0_8000_0000_0000, 5'b00010);
    chk(rsp.fault, 1'b0);
    chk(rsp.addr, 49'h1_8000_0000_0000);
    xact(49'h1_0000_0000_0000, 5'b00010);
    chk(rsp.fault, 1'b1);
    wb(1'b0, OFS_STATUS, '0);
    chk(rdat, 32'hA);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
